// file: khm_pkg.sv
package khm_pkg;

  // ****************************************
  // Microcontroller-side addresses
  // ****************************************
  localparam logic [14:0] KHM_ADDR_DATA   = 15'h7FF1;
  localparam logic [14:0] KHM_ADDR_STATUS = 15'h7FF2;
  localparam logic [14:0] KHM_ADDR_AUX    = 15'h7FFA;
  localparam logic [14:0] KHM_ADDR_FLAG   = 15'h7FFD;

  // ****************************************
  // Host I/O ports
  // ****************************************
  localparam logic [15:0] KHM_PORT_DATA = 16'h0060;
  localparam logic [15:0] KHM_PORT_CMD  = 16'h0064;
  localparam int          KHM_SA2_BIT   = 2;

  // ****************************************
  // Status bit positions and reset values
  // ****************************************
  localparam int         KHM_ST_OBF  = 0;
  localparam int         KHM_ST_IBF  = 1;
  localparam int         KHM_ST_CD   = 3;
  localparam int         KHM_ST_AUX  = 5;
  localparam logic [7:0] KHM_HW_MASK = 8'h0B;
  localparam logic [7:0] KHM_RST_GP  = 8'h00;
  localparam logic [7:0] KHM_RST_BYTE = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } khm_mcu_req_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } khm_word_t;

  typedef struct packed {
    logic obf_en;
    logic fw_ctrl;
    logic aux_hw;
  } khm_cfg_t;

endpackage : khm_pkg

// file: khm_buf2.sv
`timescale 1ns/100ps
module khm_buf2
  import khm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            rd_ix;
    logic            wr_ix;
    logic [1:0]      cnt;
  } khm_buf_st_t;

  khm_buf_st_t st_q;
  khm_buf_st_t st_d;
  logic        push;
  logic        pop;

  always_comb
  begin
    st_d = st_q;
    push = in_valid && (st_q.cnt != 2'h2);
    pop  = out_ready && (st_q.cnt != 2'h0);
    if (push)
    begin
      st_d.mem[st_q.wr_ix] = in_data;
      st_d.wr_ix = ~st_q.wr_ix;
    end
    if (pop)
    begin
      st_d.rd_ix = ~st_q.rd_ix;
    end
    st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign in_ready  = (st_q.cnt != 2'h2);
  assign out_valid = (st_q.cnt != 2'h0);
  assign out_data  = st_q.mem[st_q.rd_ix];

  count_bound_a: assert property (@(posedge mclk) disable iff (!nrst) st_q.cnt <= 2'h2)
    else $error("buffer count out of range");

endmodule : khm_buf2

// file: khm_mailbox.sv
`timescale 1ns/100ps
// How it works
// (RULE1) Host data read clears output-full and both output-full signals.
// (RULE2) Host command write loads input buffer, sets command bit and input-full.
// (RULE3) Micro write to primary or aux location loads read buffer, sets output-full; code ignores the write while the buffer holds 2 bytes.
// (RULE4) Primary write also sets keyboard output-full signal driving keyboard interrupt.
// (RULE5) Aux write also sets aux output-full signal driving mouse interrupt.
// (RULE6) Micro read of data location returns host byte and clears input-full.
// (RULE7) Status bits 7,6,4,2 and soft bit 5 are micro read/write.
// (RULE8) Host sees status read-only; micro cannot write bits 0,1,3.
// (RULE9) Host buffer write copies SA2 into status bit 3.
// (RULE10) Input-full raises micro interrupt when enabled; cleared by micro read.
// (RULE11) Output-full clears when host reads output data.
// (RULE12) Aux status bit set by aux write, cleared by primary write.
// (RULE13) Keyboard signal resets to zero and clears on host data read.
// (RULE14) Firmware control: flag location bit 0 sets or clears keyboard signal.
// (RULE15) Flag location reads zeros above bit 0, bit 0 current keyboard value.
// (RULE16) Keyboard interrupt low when disabled, else hardware flag or firmware latch.
// (RULE17) Mouse interrupt low when disabled, else aux flag; select picks bit 5.
// (RULE18) Aux signal resets to zero and clears on host data read.
// (RULE19) Host sends commands by I/O writes to port 0x64.
// (RULE20) Host data write loads input buffer, clears command bit, sets input-full.
// (RULE21) Host port accesses count only when address-enable shows non-DMA cycle.
// (RULE22) Host waits for input-full clear before writing again.
// (RULE23) Host status read returns the status byte without altering flags.
module khm_mailbox
  import khm_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [15:0]  host_sa,
  input  wire logic         host_aen,
  input  wire logic         host_ior_n,
  input  wire logic         host_iow_n,
  input  wire logic [7:0]   host_sd_in,
  output logic [7:0]        host_sd_out,
  output logic              host_sd_oe,
  input  wire khm_mcu_req_t mcu_req,
  output logic [7:0]        mcu_rdata,
  input  wire khm_cfg_t     cfg,
  input  wire logic         ibf_irq_en,
  output logic              input_full_cpu_interrupt,
  output logic              keyboard_interrupt_line,
  output logic              mouse_interrupt_line
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] aen_s;
    logic [1:0] ior_n_s;
    logic [1:0] iow_n_s;
    logic [1:0][15:0] sa_s;
    logic [1:0][7:0]  sd_s;
    logic       rd_act;
    logic       wr_act;
    logic [7:0] in_byte;
    logic [7:0] gp_bits;
    logic       input_full_flag;
    logic       output_full_flag;
    logic       cmd_bit;
    logic       aux_out_full_bit;
    logic       kbd_out_full_sig;
    logic       aux_out_full_sig;
    logic       fw_latch;
    logic [7:0] sd_out;
    logic       sd_oe;
    logic [7:0] rdata;
    logic       ibf_irq;
    logic       kbd_irq;
    logic       mouse_irq;
  } khm_st_t;

  khm_st_t    st_q;
  khm_st_t    st_d;
  logic       out_vld;
  logic       out_rdy;
  logic [7:0] out_byte;
  logic       buf_in_rdy;
  khm_word_t  mcu_out;

  logic       h_sel;
  logic       h_rd_edge;
  logic       h_wr_edge;
  logic       h_data;
  logic       h_cmd;
  logic       m_wr_pri;
  logic       m_wr_aux;
  logic       m_rd_data;
  logic       m_wr_stat;
  logic       m_wr_flag;
  logic       data_rd;
  logic       kbd_val;
  logic [7:0] status;

  // ****************************************
  // Output data buffer
  // ****************************************
  assign mcu_out = '{vld: m_wr_pri || m_wr_aux, data: mcu_req.wdata};

  khm_buf2 u_obuf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (mcu_out.vld),
    .in_ready  (buf_in_rdy),
    .in_data   (mcu_out.data),
    .out_valid (out_vld),
    .out_ready (out_rdy),
    .out_data  (out_byte)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    st_d.aen_s   = {st_q.aen_s[0], host_aen};
    st_d.ior_n_s = {st_q.ior_n_s[0], host_ior_n};
    st_d.iow_n_s = {st_q.iow_n_s[0], host_iow_n};
    st_d.sa_s    = {st_q.sa_s[0], host_sa};
    st_d.sd_s    = {st_q.sd_s[0], host_sd_in};
    h_sel = !st_q.aen_s[1]
            && ((st_q.sa_s[1] == KHM_PORT_DATA) || (st_q.sa_s[1] == KHM_PORT_CMD)); // [RULE21]
    h_rd_edge = h_sel && !st_q.ior_n_s[1] && !st_q.rd_act;
    h_wr_edge = h_sel && !st_q.iow_n_s[1] && !st_q.wr_act;
    h_data = (st_q.sa_s[1] == KHM_PORT_DATA);
    h_cmd  = (st_q.sa_s[1] == KHM_PORT_CMD);
    st_d.rd_act = h_sel && !st_q.ior_n_s[1];
    st_d.wr_act = h_sel && !st_q.iow_n_s[1];

    m_wr_pri  = mcu_req.wr && (mcu_req.addr == KHM_ADDR_DATA) && buf_in_rdy;
    m_wr_aux  = mcu_req.wr && (mcu_req.addr == KHM_ADDR_AUX) && buf_in_rdy;
    m_rd_data = mcu_req.rd && (mcu_req.addr == KHM_ADDR_DATA);
    m_wr_stat = mcu_req.wr && (mcu_req.addr == KHM_ADDR_STATUS);
    m_wr_flag = mcu_req.wr && (mcu_req.addr == KHM_ADDR_FLAG);
    data_rd   = h_rd_edge && h_data;
    out_rdy   = data_rd && out_vld;

    // Host writes to input buffer
    if (h_wr_edge)
    begin
      st_d.in_byte = st_q.sd_s[1];                              // [RULE2] [RULE20]
      st_d.cmd_bit = st_q.sa_s[1][KHM_SA2_BIT];                 // [RULE9] [RULE19]
    end

    // Input-full: set wins over micro read
    if (h_wr_edge)
    begin
      st_d.input_full_flag = 1'b1;                              // [RULE2] [RULE20]
    end
    else if (m_rd_data)
    begin
      st_d.input_full_flag = 1'b0;                              // [RULE6]
    end

    // Output-full and aux flags: micro write wins over host read
    if (mcu_out.vld)
    begin
      st_d.output_full_flag = 1'b1;                             // [RULE3]
      st_d.aux_out_full_bit = m_wr_aux;                         // [RULE12]
    end
    else if (data_rd && out_vld)
    begin
      st_d.output_full_flag = 1'b0;                             // [RULE1] [RULE11]
    end

    if (m_wr_pri)
    begin
      st_d.kbd_out_full_sig = 1'b1;                             // [RULE4]
    end
    else if (data_rd)
    begin
      st_d.kbd_out_full_sig = 1'b0;                             // [RULE13]
    end
    if (m_wr_aux)
    begin
      st_d.aux_out_full_sig = 1'b1;                             // [RULE5]
    end
    else if (data_rd)
    begin
      st_d.aux_out_full_sig = 1'b0;                             // [RULE18]
    end

    if (m_wr_flag)
    begin
      st_d.fw_latch = mcu_req.wdata[0];                         // [RULE14]
    end

    if (m_wr_stat)
    begin
      st_d.gp_bits = mcu_req.wdata & ~KHM_HW_MASK;              // [RULE7] [RULE8]
    end

    // Status assembly
    status = st_q.gp_bits;                                      // [RULE7]
    if (cfg.aux_hw)
    begin
      status[KHM_ST_AUX] = st_q.aux_out_full_bit;               // [RULE17]
    end
    status[KHM_ST_CD]  = st_q.cmd_bit;
    status[KHM_ST_IBF] = st_q.input_full_flag;
    status[KHM_ST_OBF] = st_q.output_full_flag;

    // Host read data drive
    st_d.sd_oe = st_d.rd_act;
    if (h_rd_edge)
    begin
      st_d.sd_out = h_cmd ? status : out_byte;                  // [RULE23]
    end

    // Micro read data
    kbd_val = cfg.fw_ctrl ? st_q.fw_latch : st_q.kbd_out_full_sig;
    st_d.rdata = KHM_RST_BYTE;
    if (mcu_req.rd)
    begin
      unique case (mcu_req.addr)
        KHM_ADDR_DATA:   st_d.rdata = st_q.in_byte;             // [RULE6]
        KHM_ADDR_STATUS: st_d.rdata = status;
        KHM_ADDR_FLAG:   st_d.rdata = {7'h00, kbd_val};         // [RULE15]
        default:         st_d.rdata = KHM_RST_BYTE;
      endcase
    end

    // Interrupts
    st_d.ibf_irq   = ibf_irq_en && st_d.input_full_flag;        // [RULE10]
    st_d.kbd_irq   = cfg.obf_en
                     && (cfg.fw_ctrl ? st_d.fw_latch : st_d.kbd_out_full_sig); // [RULE16]
    st_d.mouse_irq = cfg.obf_en && st_d.aux_out_full_sig;       // [RULE17]
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= '0;
      st_q.aen_s   <= 2'h3;
      st_q.ior_n_s <= 2'h3;
      st_q.iow_n_s <= 2'h3;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_sd_out               = st_q.sd_out;
  assign host_sd_oe                = st_q.sd_oe;
  assign mcu_rdata                 = st_q.rdata;
  assign input_full_cpu_interrupt  = st_q.ibf_irq;
  assign keyboard_interrupt_line   = st_q.kbd_irq;
  assign mouse_interrupt_line      = st_q.mouse_irq;

  // ****************************************
  // Checks
  // ****************************************
  host_read_clr_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE1]
    (data_rd && !mcu_out.vld) |=> !st_q.kbd_out_full_sig && !st_q.aux_out_full_sig)
    else $error("host data read left output-full signals set");

  cmd_write_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE2]
    (h_wr_edge && h_cmd) |=> st_q.cmd_bit && st_q.input_full_flag)
    else $error("command write did not set flags");

  data_write_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE20]
    (h_wr_edge && h_data) |=> !st_q.cmd_bit && st_q.input_full_flag)
    else $error("data write did not set flags");

  obf_set_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE3]
    mcu_out.vld |=> st_q.output_full_flag)
    else $error("output-full not set");

  obf_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE11]
    (data_rd && out_vld && !mcu_out.vld) |=> !st_q.output_full_flag)
    else $error("output-full not cleared by host data read");

  kbd_set_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE4]
    m_wr_pri |=> st_q.kbd_out_full_sig)
    else $error("keyboard output-full signal not set");

  aux_set_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE5]
    m_wr_aux |=> st_q.aux_out_full_sig && st_q.aux_out_full_bit)
    else $error("aux output-full not set");

  aux_bit_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE12]
    m_wr_pri |=> !st_q.aux_out_full_bit)
    else $error("aux bit not cleared by primary write");

  ibf_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE6]
    (m_rd_data && !h_wr_edge) |=> !st_q.input_full_flag)
    else $error("input-full not cleared by micro read");

  ibf_data_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE6]
    m_rd_data |=> (mcu_rdata == $past(st_q.in_byte)))
    else $error("micro read returned wrong host byte");

  sa2_copy_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE9]
    h_wr_edge |=> (st_q.cmd_bit == $past(st_q.sa_s[1][KHM_SA2_BIT])))
    else $error("command bit does not follow address bit");

  ibf_irq_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE10]
    input_full_cpu_interrupt == (st_q.input_full_flag && $past(ibf_irq_en)))
    else $error("input-full interrupt mismatch");

  hw_bits_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE8]
    (m_wr_stat && !h_wr_edge && !data_rd) |=> ((st_q.gp_bits & KHM_HW_MASK) == 8'h00)
      && $stable(st_q.input_full_flag) && $stable(st_q.output_full_flag) && $stable(st_q.cmd_bit))
    else $error("micro write changed hardware status bits");

  keyboard_interrupt_line_off_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE16]
    !cfg.obf_en |=> !keyboard_interrupt_line && !mouse_interrupt_line)
    else $error("interrupt driven while disabled");

  keyboard_interrupt_line_follow_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE16]
    keyboard_interrupt_line == ($past(cfg.obf_en)
      && ($past(cfg.fw_ctrl) ? st_q.fw_latch : st_q.kbd_out_full_sig)))
    else $error("keyboard interrupt does not follow its source");

  mouse_interrupt_line_follow_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE17]
    mouse_interrupt_line == ($past(cfg.obf_en) && st_q.aux_out_full_sig))
    else $error("mouse interrupt does not follow aux signal");

  fw_latch_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE14]
    m_wr_flag |=> (st_q.fw_latch == $past(mcu_req.wdata[0])))
    else $error("firmware latch not loaded");

  flag_read_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE15]
    (mcu_req.rd && mcu_req.addr == KHM_ADDR_FLAG) |=> (mcu_rdata[7:1] == 7'h00))
    else $error("flag location upper bits nonzero");

  flag_bit0_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE15]
    (mcu_req.rd && mcu_req.addr == KHM_ADDR_FLAG)
      |=> (mcu_rdata[0] == $past(kbd_val)))
    else $error("flag location bit 0 wrong");

  status_keep_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE23]
    (h_rd_edge && h_cmd && !h_wr_edge && !mcu_req.wr && !mcu_req.rd)
      |=> $stable(st_q.input_full_flag) && $stable(st_q.output_full_flag))
    else $error("status read altered a flag");

  dma_ignore_a: assert property (@(posedge mclk) disable iff (!nrst) // [RULE21]
    st_q.aen_s[1] |=> !st_q.wr_act && !st_q.rd_act && !host_sd_oe)
    else $error("host access taken during DMA cycle");

endmodule : khm_mailbox

// file: khm_host_model.sv
`timescale 1ns/100ps
module khm_host_model
  import khm_pkg::*;
(
  input  wire logic       mclk,
  output logic [15:0]     host_sa,
  output logic            host_aen,
  output logic            host_ior_n,
  output logic            host_iow_n,
  output logic [7:0]      host_sd_in,
  input  wire logic [7:0] host_sd_out,
  input  wire logic       host_sd_oe
);
  initial
  begin
    host_sa    = 16'h0000;
    host_aen   = 1'b0;
    host_ior_n = 1'b1;
    host_iow_n = 1'b1;
    host_sd_in = 8'h00;
  end

  // ****************************************
  // Host I/O write, strobe held 5 cycles
  // ****************************************
  task automatic io_wr(input logic [15:0] port, input logic [7:0] data, input logic dma);
    host_sa    = port;
    host_aen   = dma;
    host_sd_in = data;
    host_iow_n = 1'b0;
    repeat (5) @(negedge mclk);
    host_iow_n = 1'b1;
    host_sd_in = ~data;
    repeat (6) @(negedge mclk);
    host_aen   = 1'b0;
  endtask : io_wr

  // ****************************************
  // Host I/O read, sampled before release
  // ****************************************
  task automatic io_rd(input logic [15:0] port, output logic [7:0] data, output logic oe);
    host_sa    = port;
    host_ior_n = 1'b0;
    repeat (5) @(negedge mclk);
    data       = host_sd_out;
    oe         = host_sd_oe;
    host_ior_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask : io_rd
endmodule : khm_host_model

// file: keyboard_host_mailbox_port_test.sv
`timescale 1ns/100ps
module keyboard_host_mailbox_port_test
  import khm_pkg::*;
;
  logic         mclk;
  logic         nrst;
  logic [15:0]  host_sa;
  logic         host_aen;
  logic         host_ior_n;
  logic         host_iow_n;
  logic [7:0]   host_sd_in;
  logic [7:0]   host_sd_out;
  logic         host_sd_oe;
  khm_mcu_req_t mcu_req;
  logic [7:0]   mcu_rdata;
  khm_cfg_t     cfg;
  logic         ibf_irq_en;
  logic         ibf_irq;
  logic         kbd_irq;
  logic         mse_irq;
  logic [7:0]   irqs;
  logic [7:0]   v;
  logic         oe;
  int           bad_count;
  int           comparisons;
  int           cycles;

  assign irqs = {5'h00, ibf_irq, kbd_irq, mse_irq};

  khm_mailbox i_khm_mailbox (
    .mclk                     (mclk),
    .nrst                     (nrst),
    .host_sa                  (host_sa),
    .host_aen                 (host_aen),
    .host_ior_n               (host_ior_n),
    .host_iow_n               (host_iow_n),
    .host_sd_in               (host_sd_in),
    .host_sd_out              (host_sd_out),
    .host_sd_oe               (host_sd_oe),
    .mcu_req                  (mcu_req),
    .mcu_rdata                (mcu_rdata),
    .cfg                      (cfg),
    .ibf_irq_en               (ibf_irq_en),
    .input_full_cpu_interrupt (ibf_irq),
    .keyboard_interrupt_line  (kbd_irq),
    .mouse_interrupt_line     (mse_irq)
  );

  khm_host_model i_khm_host_model (
    .mclk        (mclk),
    .host_sa     (host_sa),
    .host_aen    (host_aen),
    .host_ior_n  (host_ior_n),
    .host_iow_n  (host_iow_n),
    .host_sd_in  (host_sd_in),
    .host_sd_out (host_sd_out),
    .host_sd_oe  (host_sd_oe)
  );

  initial
  begin
    mclk = 1'b0;
  end
  always #4 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic mcu_wr(input logic [14:0] a, input logic [7:0] d);
    mcu_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    mcu_req = '0;
    repeat (2) @(negedge mclk);
  endtask : mcu_wr

  task automatic mcu_rd(input logic [14:0] a, output logic [7:0] d);
    mcu_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    mcu_req = '0;
    d = mcu_rdata;
    repeat (2) @(negedge mclk);
  endtask : mcu_rd

  task automatic st(input logic [7:0] exp);
    mcu_rd(KHM_ADDR_STATUS, v);
    check("status", v, exp);
  endtask : st

  task automatic hrd(input logic [15:0] p, input logic [7:0] exp);
    i_khm_host_model.io_rd(p, v, oe);
    check("host read", v, exp);
    check("host oe", {7'h00, oe}, 8'h01);
  endtask : hrd

  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    bad_count  = 0;
    comparisons = 0;
    cycles     = 0;
    nrst       = 1'b0;
    mcu_req    = '0;
    cfg        = '{obf_en: 1'b1, fw_ctrl: 1'b0, aux_hw: 1'b1};
    ibf_irq_en = 1'b1;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    hrd(KHM_PORT_CMD, 8'h00);
    mcu_rd(KHM_ADDR_FLAG, v);
    check("flag", v, 8'h00);
    check("irqs", irqs, 8'h00);
    i_khm_host_model.io_wr(KHM_PORT_DATA, 8'hA5, 1'b0);
    check("irqs", irqs, 8'h04);
    st(8'h02);
    hrd(KHM_PORT_CMD, 8'h02);
    mcu_rd(KHM_ADDR_DATA, v);
    check("mcu data", v, 8'hA5);
    check("irqs", irqs, 8'h00);
    st(8'h00);
    i_khm_host_model.io_wr(KHM_PORT_CMD, 8'h3C, 1'b0);
    st(8'h0A);
    mcu_rd(KHM_ADDR_DATA, v);
    check("mcu cmd", v, 8'h3C);
    i_khm_host_model.io_wr(KHM_PORT_DATA, 8'h77, 1'b1);
    st(8'h08);
    mcu_wr(KHM_ADDR_STATUS, 8'hFF);
    st(8'hDC);
    check("irqs", irqs, 8'h00);
    cfg.aux_hw = 1'b0;
    st(8'hFC);
    hrd(KHM_PORT_CMD, 8'hFC);
    mcu_wr(KHM_ADDR_STATUS, 8'h00);
    cfg.aux_hw = 1'b1;
    mcu_wr(KHM_ADDR_DATA, 8'h11);
    check("irqs", irqs, 8'h02);
    st(8'h09);
    mcu_rd(KHM_ADDR_FLAG, v);
    check("flag", v, 8'h01);
    mcu_wr(KHM_ADDR_AUX, 8'h22);
    check("irqs", irqs, 8'h03);
    st(8'h29);
    mcu_wr(KHM_ADDR_DATA, 8'h33);
    st(8'h29);
    hrd(KHM_PORT_DATA, 8'h11);
    check("irqs", irqs, 8'h00);
    mcu_rd(KHM_ADDR_STATUS, v);
    check("status", v & 8'hDF, 8'h08);
    hrd(KHM_PORT_DATA, 8'h22);
    mcu_wr(KHM_ADDR_AUX, 8'h44);
    st(8'h29);
    mcu_wr(KHM_ADDR_DATA, 8'h55);
    st(8'h09);
    check("kbd irq", irqs & 8'h06, 8'h02);
    hrd(KHM_PORT_DATA, 8'h44);
    hrd(KHM_PORT_DATA, 8'h55);
    check("irqs", irqs, 8'h00);
    cfg.obf_en = 1'b0;
    mcu_wr(KHM_ADDR_AUX, 8'h66);
    check("irqs", irqs, 8'h00);
    mcu_wr(KHM_ADDR_DATA, 8'h67);
    check("irqs", irqs, 8'h00);
    hrd(KHM_PORT_DATA, 8'h66);
    hrd(KHM_PORT_DATA, 8'h67);
    cfg = '{obf_en: 1'b1, fw_ctrl: 1'b1, aux_hw: 1'b1};
    mcu_wr(KHM_ADDR_FLAG, 8'hFF);
    check("irqs", irqs, 8'h02);
    mcu_rd(KHM_ADDR_FLAG, v);
    check("flag", v, 8'h01);
    mcu_wr(KHM_ADDR_DATA, 8'h78);
    mcu_wr(KHM_ADDR_FLAG, 8'h00);
    check("irqs", irqs, 8'h00);
    mcu_rd(KHM_ADDR_FLAG, v);
    check("flag", v, 8'h00);
    hrd(KHM_PORT_DATA, 8'h78);
    ibf_irq_en = 1'b0;
    i_khm_host_model.io_wr(KHM_PORT_DATA, 8'h5A, 1'b0);
    check("irqs", irqs, 8'h00);
    st(8'h02);
    mcu_rd(KHM_ADDR_DATA, v);
    check("mcu data", v, 8'h5A);
    mcu_wr(KHM_ADDR_FLAG, 8'h01);
    mcu_wr(KHM_ADDR_AUX, 8'h21);
    check("irqs", irqs, 8'h03);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    check("irqs", irqs, 8'h00);
    mcu_rd(KHM_ADDR_FLAG, v);
    check("flag", v, 8'h00);
    st(8'h00);
    hrd(KHM_PORT_CMD, 8'h00);
    tally_and_finish();
  end
endmodule : keyboard_host_mailbox_port_test
